/* File: rtl/ffs_consts.svh */
// Constants for the four-phase fetch/execute sequencer.
`ifndef FFS_CONSTS_SVH
`define FFS_CONSTS_SVH
`define FFS_DATA_W        8
`define FFS_PC_W          12
`define FFS_IW            15
`define FFS_PC_RESET      12'h000
`define FFS_PAGE_MSB      11
`define FFS_PAGE_LSB      8
`define FFS_XTAL_WAKE_CLKS 1024
`define FFS_RC_WAKE_CLKS   1
`define FFS_WAKE_CNT_W    11
`define FFS_OP_W          4
`define FFS_OP_ADD        4'h0
`define FFS_OP_SUB        4'h1
`define FFS_OP_AND        4'h2
`define FFS_OP_OR         4'h3
`define FFS_OP_XOR        4'h4
`define FFS_OP_CPL        4'h5
`define FFS_OP_RL         4'h6
`define FFS_OP_RR         4'h7
`define FFS_OP_INC        4'h8
`define FFS_OP_DEC        4'h9
`define FFS_OP_PASS       4'hA
`define FFS_OP_SZ         4'hB
`endif

/* File: rtl/ffs_pkg.sv */
// Types for the four-phase fetch/execute sequencer.
package ffs_pkg;
  typedef enum logic [1:0] {
    FFS_PH_FETCH    = 2'b00,
    FFS_PH_DECODE_A = 2'b01,
    FFS_PH_DECODE_B = 2'b10,
    FFS_PH_EXECUTE  = 2'b11
  } ffs_phase_t;
  typedef enum logic [1:0] {
    FFS_RUN   = 2'b00,
    FFS_SLEEP = 2'b01,
    FFS_WAKE  = 2'b10
  } ffs_power_t;
endpackage

/* File: rtl/ffs_alu.sv */
// Eight-bit arithmetic and logic unit of the sequencer.
`timescale 1ns/1ps
`include "ffs_consts.svh"
module ffs_alu (
  input  wire logic [`FFS_OP_W-1:0]   op,
  input  wire logic [`FFS_DATA_W-1:0] acc,
  input  wire logic [`FFS_DATA_W-1:0] operand,
  input  wire logic                   carry_in,
  output logic      [`FFS_DATA_W-1:0] result,
  output logic                        carry_out,
  output logic                        zero
);
  logic [`FFS_DATA_W:0] wide;
  always_comb begin
    wide = {1'b0, acc};
    unique case (op)
      `FFS_OP_ADD: wide = {1'b0, acc} + {1'b0, operand};
      `FFS_OP_SUB: wide = {1'b0, acc} - {1'b0, operand};
      `FFS_OP_AND: wide = {1'b0, acc & operand};
      `FFS_OP_OR:  wide = {1'b0, acc | operand};
      `FFS_OP_XOR: wide = {1'b0, acc ^ operand};
      `FFS_OP_CPL: wide = {1'b0, ~operand};
      `FFS_OP_RL:  wide = {operand[7], operand[6:0], carry_in};
      `FFS_OP_RR:  wide = {operand[0], carry_in, operand[7:1]};
      `FFS_OP_INC: wide = {1'b0, operand} + 9'h001;
      `FFS_OP_DEC: wide = {1'b0, operand} - 9'h001;
      `FFS_OP_PASS: wide = {1'b0, operand};
      `FFS_OP_SZ:  wide = {1'b0, operand};
      default:     wide = {1'b0, acc};
    endcase
    result    = wide[`FFS_DATA_W-1:0];
    carry_out = wide[`FFS_DATA_W];
    zero      = (wide[`FFS_DATA_W-1:0] == 8'h00);
  end
endmodule

/* File: rtl/ffs_sequencer.sv */
// Four-phase fetch/execute sequencer with wake-up start-up wait.
//
// Contract
// - Four non-overlapping phases rotate in fixed order from the system clock.
// - First phase advances the program counter and fetches the next word. The code holds the counter in the first phase of a dummy cycle.
// - Second to fourth phases decode and execute the current instruction.
// - One instruction cycle is exactly four system clock periods.
// - Fetch of next instruction overlaps execution of the current one.
// - Jump and call take two instruction cycles.
// - An 8-bit ALU does arithmetic, logic, rotate, inc, dec, branch tests.
// - Operands and results travel through accumulator and ALU.
// - Crystal or clock-crystal wake-up waits 1024 clock periods.
// - A taken skip discards the prefetched word and idles one cycle.
// - Writing the low PC byte branches within the page with a dummy cycle.
`timescale 1ns/1ps
`include "ffs_consts.svh"
module ffs_sequencer (
  input  wire logic                   sys_clk,
  input  wire logic                   reset_n,
  input  wire logic                   power_down_req,
  input  wire logic                   wake_req,
  input  wire logic                   osc_is_crystal,
  input  wire logic [`FFS_IW-1:0]     fetch_word,
  input  wire logic [`FFS_OP_W-1:0]   dec_alu_op,
  input  wire logic [`FFS_DATA_W-1:0] dec_operand,
  input  wire logic                   dec_acc_write,
  input  wire logic                   dec_is_jump,
  input  wire logic [`FFS_PC_W-1:0]   dec_jump_target,
  input  wire logic                   dec_is_skip,
  input  wire logic                   dec_skip_on_zero,
  input  wire logic                   dec_pcl_write,
  output logic                        phase_fetch,
  output logic                        phase_decode_a,
  output logic                        phase_decode_b,
  output logic                        phase_execute,
  output logic [`FFS_PC_W-1:0]        program_addr,
  output logic [`FFS_IW-1:0]          instr_word,
  output logic                        instr_valid,
  output logic [`FFS_DATA_W-1:0]      acc_value,
  output logic                        running
);
  ffs_pkg::ffs_phase_t            phase_r, phase_nxt;
  ffs_pkg::ffs_power_t            pwr_r, pwr_nxt;
  logic [`FFS_WAKE_CNT_W-1:0]     wake_cnt_r, wake_cnt_nxt;
  logic [`FFS_PC_W-1:0]           pc_r, pc_nxt;
  logic [`FFS_IW-1:0]             ir_r, ir_nxt;
  logic                           valid_r, valid_nxt;
  logic                           bubble_r, bubble_nxt;
  logic [`FFS_DATA_W-1:0]         acc_r, acc_nxt;
  logic                           carry_r, carry_nxt;
  logic [3:0]                     ph_oh_r, ph_oh_nxt;
  logic                           pd_s1_r, pd_s2_r, wk_s1_r, wk_s2_r;
  logic                           xt_s1_r, xt_s2_r;
  logic [`FFS_DATA_W-1:0]         alu_res;
  logic                           alu_c, alu_z;
  logic                           run, run_nxt;
  logic                           running_r;

  // Pins from outside the clock domain pass two flops first.
  always_ff @(posedge sys_clk) begin
    pd_s1_r <= power_down_req;
    pd_s2_r <= pd_s1_r;
    wk_s1_r <= wake_req;
    wk_s2_r <= wk_s1_r;
    xt_s1_r <= osc_is_crystal;
    xt_s2_r <= xt_s1_r;
  end

  ffs_alu u_alu (
    .op        (dec_alu_op),
    .acc       (acc_r),
    .operand   (dec_operand),
    .carry_in  (carry_r),
    .result    (alu_res),
    .carry_out (alu_c),
    .zero      (alu_z)
  );

  assign run = (pwr_r == ffs_pkg::FFS_RUN);
  assign run_nxt = (pwr_nxt == ffs_pkg::FFS_RUN);

  // Power state and start-up wait. Sleep is entered only on a cycle
  // boundary so that no instruction is left half executed.
  always_comb begin
    pwr_nxt      = pwr_r;
    wake_cnt_nxt = wake_cnt_r;
    unique case (pwr_r)
      ffs_pkg::FFS_RUN: begin
        if (pd_s2_r && phase_r == ffs_pkg::FFS_PH_EXECUTE) begin
          pwr_nxt = ffs_pkg::FFS_SLEEP;
        end
      end
      ffs_pkg::FFS_SLEEP: begin
        if (wk_s2_r) begin
          pwr_nxt = ffs_pkg::FFS_WAKE;
          if (xt_s2_r) begin
            wake_cnt_nxt = 11'(`FFS_XTAL_WAKE_CLKS - 1);
          end else begin
            wake_cnt_nxt = 11'(`FFS_RC_WAKE_CLKS - 1);
          end
        end
      end
      ffs_pkg::FFS_WAKE: begin
        if (wake_cnt_r == 11'h000) begin
          pwr_nxt = ffs_pkg::FFS_RUN;
        end else begin
          wake_cnt_nxt = wake_cnt_r - 11'h001;
        end
      end
      default: pwr_nxt = ffs_pkg::FFS_RUN;
    endcase
  end

  // Phase rotation, fetch pipeline, program counter and accumulator.
  always_comb begin
    phase_nxt  = phase_r;
    pc_nxt     = pc_r;
    ir_nxt     = ir_r;
    valid_nxt  = valid_r;
    bubble_nxt = bubble_r;
    acc_nxt    = acc_r;
    carry_nxt  = carry_r;
    if (run) begin
      unique case (phase_r)
        ffs_pkg::FFS_PH_FETCH:    phase_nxt = ffs_pkg::FFS_PH_DECODE_A;
        ffs_pkg::FFS_PH_DECODE_A: phase_nxt = ffs_pkg::FFS_PH_DECODE_B;
        ffs_pkg::FFS_PH_DECODE_B: phase_nxt = ffs_pkg::FFS_PH_EXECUTE;
        ffs_pkg::FFS_PH_EXECUTE:  phase_nxt = ffs_pkg::FFS_PH_FETCH;
      endcase
      if (phase_r == ffs_pkg::FFS_PH_FETCH) begin
        // The word at pc is latched while the previous one executes.
        ir_nxt     = fetch_word;
        valid_nxt  = !bubble_r;
        bubble_nxt = 1'b0;
        // A dummy cycle holds the counter, so the redirected word is
        // fetched again in the next cycle as a real one.
        if (!bubble_r) begin
          pc_nxt = pc_r + 12'h001;
        end
      end
      if (phase_r == ffs_pkg::FFS_PH_EXECUTE && valid_r) begin
        if (dec_acc_write) begin
          acc_nxt   = alu_res;
          carry_nxt = alu_c;
        end
        if (dec_is_jump) begin
          // Target takes effect next cycle; prefetched word is dropped.
          pc_nxt     = dec_jump_target;
          bubble_nxt = 1'b1;
        end else if (dec_pcl_write) begin
          pc_nxt     = {pc_r[`FFS_PAGE_MSB:`FFS_PAGE_LSB], alu_res};
          bubble_nxt = 1'b1;
        end else if (dec_is_skip && (alu_z == dec_skip_on_zero)) begin
          // Step past the discarded word before the dummy cycle holds.
          pc_nxt     = pc_r + 12'h001;
          bubble_nxt = 1'b1;
        end
      end
    end
  end

  always_comb begin
    ph_oh_nxt = 4'h0;
    if (run_nxt) begin
      ph_oh_nxt[phase_nxt] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      phase_r    <= ffs_pkg::FFS_PH_FETCH;
      ph_oh_r    <= 4'h1;
      pwr_r      <= ffs_pkg::FFS_RUN;
      wake_cnt_r <= 11'h000;
      pc_r       <= `FFS_PC_RESET;
      ir_r       <= 15'h0000;
      valid_r    <= 1'b0;
      bubble_r   <= 1'b0;
      acc_r      <= 8'h00;
      carry_r    <= 1'b0;
      running_r  <= 1'b1;
    end else begin
      phase_r    <= phase_nxt;
      ph_oh_r    <= ph_oh_nxt;
      pwr_r      <= pwr_nxt;
      wake_cnt_r <= wake_cnt_nxt;
      pc_r       <= pc_nxt;
      ir_r       <= ir_nxt;
      valid_r    <= valid_nxt;
      bubble_r   <= bubble_nxt;
      acc_r      <= acc_nxt;
      carry_r    <= carry_nxt;
      running_r  <= run_nxt;
    end
  end

  assign phase_fetch    = ph_oh_r[0];
  assign phase_decode_a = ph_oh_r[1];
  assign phase_decode_b = ph_oh_r[2];
  assign phase_execute  = ph_oh_r[3];
  assign program_addr   = pc_r;
  assign instr_word     = ir_r;
  assign instr_valid    = valid_r;
  assign acc_value      = acc_r;
  assign running        = running_r;

  // Checker helpers. The long start-up wait is measured with a counter,
  // since a long repetition would be unrolled by the property tools.
  logic                           exec_ok;
  logic [11:0]                    wake_len_r;
  logic                           wake_xtal_r;
  assign exec_ok = run && phase_r == ffs_pkg::FFS_PH_EXECUTE && valid_r;
  always_ff @(posedge sys_clk) begin
    if (!reset_n || pwr_r != ffs_pkg::FFS_WAKE) begin
      wake_len_r <= 12'h000;
    end else begin
      wake_len_r <= wake_len_r + 12'h001;
    end
    if (!reset_n) begin
      wake_xtal_r <= 1'b0;
    end else if (pwr_r == ffs_pkg::FFS_SLEEP && wk_s2_r) begin
      wake_xtal_r <= xt_s2_r;
    end
  end

  sequence s_fetch_then_decode;
    phase_fetch ##1 phase_decode_a;
  endsequence
  sequence s_decode_then_exec;
    phase_decode_b ##1 phase_execute;
  endsequence

  AST_ONEHOT: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    running ? $onehot(ph_oh_r) : (ph_oh_r == 4'h0))
    else $error("Phase outputs overlap or stay on in sleep.");
  AST_ORDER: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (phase_fetch && running) ##1 running |->
    $past(phase_fetch) && phase_decode_a)
    else $error("Phase order broken.");
  AST_PERIOD: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (phase_fetch && running) ##1 running[*3] ##1 running |->
    s_fetch_then_decode ##0 1'b1 or phase_fetch)
    else $error("Cycle is not four clocks.");
  AST_PC_INC: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (running && phase_r == ffs_pkg::FFS_PH_FETCH && !bubble_r) |=>
    pc_r == $past(pc_r) + 12'h001)
    else $error("PC not advanced in fetch.");
  AST_BUBBLE_HOLD: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (running && phase_r == ffs_pkg::FFS_PH_FETCH && bubble_r) |=>
    pc_r == $past(pc_r) && !instr_valid)
    else $error("Dummy cycle moved the PC or was marked valid.");
  AST_JUMP_BUBBLE: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (exec_ok && dec_is_jump) ##1 running[*2] |-> !instr_valid)
    else $error("Jump did not idle.");
  AST_JUMP_PC: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (exec_ok && dec_is_jump) |=> pc_r == $past(dec_jump_target))
    else $error("Jump target lost.");
  AST_PCL_PAGE: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (exec_ok && !dec_is_jump && dec_pcl_write) |=>
    pc_r[`FFS_PAGE_MSB:`FFS_PAGE_LSB] ==
    $past(pc_r[`FFS_PAGE_MSB:`FFS_PAGE_LSB]) && bubble_r)
    else $error("Low byte write left the page.");
  AST_SKIP_PC: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (exec_ok && !dec_is_jump && !dec_pcl_write && dec_is_skip &&
     alu_z == dec_skip_on_zero) |=>
    pc_r == $past(pc_r) + 12'h001 && bubble_r)
    else $error("Taken skip did not step past the next word.");
  AST_ACC: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (exec_ok && dec_acc_write) |=> acc_r == $past(alu_res))
    else $error("Accumulator not loaded.");
  AST_XTAL_WAIT: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (pwr_r == ffs_pkg::FFS_WAKE && wake_cnt_r == 11'h000 && wake_xtal_r)
    |-> wake_len_r == 12'(`FFS_XTAL_WAKE_CLKS - 1) ##1 running)
    else $error("Crystal wait wrong.");
  AST_RC_WAIT: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (pwr_r == ffs_pkg::FFS_SLEEP && wk_s2_r && !xt_s2_r) |=>
    !running ##1 running)
    else $error("RC wait wrong.");
  AST_RESET_PHASE: assert property (
    @(posedge sys_clk)
    !reset_n |=> phase_fetch)
    else $error("Reset did not restart phase.");
  AST_DECODE_SEQ: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (phase_decode_a && running) ##1 running |-> s_decode_then_exec)
    else $error("Decode phases out of order.");
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the four-phase fetch/execute sequencer.
`timescale 1ns/1ps
`include "ffs_consts.svh"
module testbench;
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  gap;
    logic [7:0]  acc;
  } ffs_note_t;
  logic                   sys_clk, reset_n, power_down_req, wake_req;
  logic                   osc_is_crystal, dec_acc_write, dec_is_jump;
  logic                   dec_is_skip, dec_skip_on_zero, dec_pcl_write;
  logic [`FFS_IW-1:0]     fetch_word, instr_word;
  logic [`FFS_OP_W-1:0]   dec_alu_op;
  logic [`FFS_DATA_W-1:0] dec_operand, acc_value, acc_exp;
  logic [`FFS_PC_W-1:0]   dec_jump_target, program_addr;
  logic                   phase_fetch, phase_decode_a, phase_decode_b;
  logic                   phase_execute, instr_valid, running, mon_on, rs;
  logic [3:0]             prev_ph;
  logic                   carry_exp;
  logic [7:0]             gap_cnt;
  int                     err_total, tests_run, cycles;
  ffs_note_t              notes [$];
  ffs_note_t              n;

  ffs_sequencer dut (.sys_clk, .reset_n, .power_down_req, .wake_req,
    .osc_is_crystal, .fetch_word, .dec_alu_op, .dec_operand, .dec_acc_write,
    .dec_is_jump, .dec_jump_target, .dec_is_skip, .dec_skip_on_zero,
    .dec_pcl_write, .phase_fetch, .phase_decode_a, .phase_decode_b,
    .phase_execute, .program_addr, .instr_word, .instr_valid, .acc_value,
    .running);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("Checks run %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Reference result with the carry in the top bit.
  function automatic logic [8:0] alu_ref(input logic [3:0] op,
                                         input logic [7:0] a, b,
                                         input logic       c);
    case (op)
      `FFS_OP_ADD: return {1'b0, a} + {1'b0, b};
      `FFS_OP_SUB: return {1'b0, a} - {1'b0, b};
      `FFS_OP_AND: return {1'b0, a & b};
      `FFS_OP_OR:  return {1'b0, a | b};
      `FFS_OP_XOR: return {1'b0, a ^ b};
      `FFS_OP_CPL: return {1'b0, ~b};
      `FFS_OP_RL:  return {b, c};
      `FFS_OP_RR:  return {b[0], c, b[7:1]};
      `FFS_OP_INC: return {1'b0, b} + 9'h001;
      `FFS_OP_DEC: return {1'b0, b} - 9'h001;
      default:     return {1'b0, b};
    endcase
  endfunction

  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Program memory model: each word carries its own address.
  always @(posedge sys_clk) begin
    #1;
    fetch_word = {3'h0, program_addr};
  end

  // Watcher: phase rotation every cycle, retired instructions against notes.
  always @(posedge sys_clk) begin
    rs = reset_n;
    #2;
    cycles++;
    if (cycles > 5000) begin
      err_total++;
      conclude();
    end
    if (rs === 1'h1 && running === 1'h1 && prev_ph != 4'h0)
      check({phase_fetch, phase_decode_a, phase_decode_b, phase_execute},
            {prev_ph[0], prev_ph[3:1]});
    else if (rs === 1'h1 && running === 1'h0)
      check({phase_fetch, phase_decode_a, phase_decode_b, phase_execute},
            4'h0);
    prev_ph = {phase_fetch, phase_decode_a, phase_decode_b, phase_execute};
    if (rs === 1'h1 && mon_on && phase_execute === 1'h1 &&
        instr_valid === 1'h1 && notes.size() > 0) begin
      n = notes.pop_front();
      check(instr_word[11:0], n.addr);
      check(acc_value, n.acc);
      if (n.gap != 8'h00) check(gap_cnt, n.gap);
      gap_cnt = 8'h00;
    end
    gap_cnt++;
  end

  // One instruction per valid execute phase; expected outcome is noted.
  task automatic run_one();
    logic [11:0] a, nxt;
    logic [7:0]  opnd;
    logic [8:0]  r;
    logic [1:0]  kind;
    logic        extra;
    do begin
      @(posedge sys_clk);
      #1;
    end while (!(phase_execute === 1'h1 && instr_valid === 1'h1));
    a = instr_word[11:0];
    kind = 2'($urandom_range(3));
    opnd = ($urandom_range(3) == 0) ? 8'h00 : 8'($urandom);
    dec_operand = opnd;
    dec_alu_op = (kind == 2'h0) ? 4'($urandom_range(11)) : `FFS_OP_PASS;
    dec_acc_write = (kind == 2'h0) && 1'($urandom);
    dec_is_jump = (kind == 2'h1);
    dec_is_skip = (kind == 2'h2);
    dec_skip_on_zero = 1'($urandom);
    dec_pcl_write = (kind == 2'h3);
    dec_jump_target = 12'($urandom);
    r = alu_ref(dec_alu_op, acc_exp, opnd, carry_exp);
    if (dec_acc_write) {carry_exp, acc_exp} = r;
    extra = (kind == 2'h1) || (kind == 2'h3) ||
            (kind == 2'h2 && ((opnd == 8'h00) == dec_skip_on_zero));
    nxt = a + 12'h001;
    if (kind == 2'h1) nxt = dec_jump_target;
    // The page kept is that of the counter, already one past this word.
    if (kind == 2'h3) nxt = {nxt[11:8], r[7:0]};
    if (kind == 2'h2 && extra) nxt = a + 12'h002;
    notes.push_back({nxt, extra ? 8'h08 : 8'h04, acc_exp});
  endtask

  task automatic sleep_wake(input logic xtal, input int lo, input int hi);
    int k;
    osc_is_crystal = xtal;
    power_down_req = 1'h1;
    k = 0;
    while (running !== 1'h0 && k < 40) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    power_down_req = 1'h0;
    repeat (4) @(posedge sys_clk);
    #1;
    check(running, 1'h0);
    wake_req = 1'h1;
    k = 0;
    while (running !== 1'h1 && k < 2000) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    wake_req = 1'h0;
    check(k >= lo && k <= hi, 1'h1);
  endtask

  initial begin
    {reset_n, power_down_req, wake_req, osc_is_crystal} = 4'h0;
    {dec_acc_write, dec_is_jump, dec_is_skip} = 3'h0;
    {dec_skip_on_zero, dec_pcl_write} = 2'h0;
    dec_alu_op = `FFS_OP_PASS;
    dec_operand = 8'h00;
    dec_jump_target = 12'h000;
    fetch_word = 15'h0000;
    carry_exp = 1'h0;
    {err_total, tests_run, cycles} = '0;
    gap_cnt = 8'h00;
    prev_ph = 4'h0;
    acc_exp = 8'h00;
    mon_on = 1'h1;
    void'($urandom(32'h891f_ff1c));
    notes.push_back({12'h000, 8'h00, 8'h00});
    repeat (2) @(posedge sys_clk);
    #1;
    check({phase_fetch, phase_decode_a, phase_decode_b, phase_execute,
           instr_valid, running, program_addr, acc_value},
          26'h210_0000);
    reset_n = 1'h1;
    for (int i = 0; i < 80; i++) run_one();
    // Drain the last note before clearing the decode inputs.
    repeat (12) @(posedge sys_clk);
    #1;
    mon_on = 1'h0;
    notes.delete();
    {dec_acc_write, dec_is_jump, dec_is_skip, dec_pcl_write} = 4'h0;
    sleep_wake(1'h0, 1, 6);
    sleep_wake(1'h1, 1024, 1030);
    repeat (20) @(posedge sys_clk);
    conclude();
  end
endmodule
